// ### verilog/tlm_pkg.sv
// Package of offsets, formats, ranges and reset values for the monitor
package tlm_pkg;

  // ************************************************************
  // Command codes of the threshold registers
  // ************************************************************
  localparam logic [7:0] CMD_OT_WARN  = 8'h51;
  localparam logic [7:0] CMD_UT_WARN  = 8'h52;
  localparam logic [7:0] CMD_UT_FAULT = 8'h53;

  // ************************************************************
  // Linear format fields and internal fixed point
  // ************************************************************
  localparam int EXP_MSB  = 15;
  localparam int EXP_LSB  = 11;
  localparam int MANT_MSB = 10;
  localparam int FRAC_W   = 16;          // Fraction bits of fixed point
  localparam int FIX_W    = 48;          // Holds 11-bit mantissa << 31

  // ************************************************************
  // Accepted ranges, degrees Celsius in fixed point (x 2^16)
  // ************************************************************
  localparam logic signed [47:0] OT_MIN = 48'sh0;
  localparam logic signed [47:0] OT_MAX = 48'shaf0000;   // +175
  localparam logic signed [47:0] UT_MIN = -48'sh370000;  // -55
  localparam logic signed [47:0] UT_MAX = 48'sh190000;   // +25

  // ************************************************************
  // Reset values, linear with exponent zero
  // ************************************************************
  localparam logic [15:0] RST_OT_WARN  = 16'h0064;       // +100
  localparam logic [15:0] RST_UT_WARN  = 16'h07d8;       // -40
  localparam logic [15:0] RST_UT_FAULT = 16'h07d3;       // -45

endpackage

// ### verilog/tlm_lin_to_fix.sv
// Linear-11 word to signed fixed point converter
`timescale 1ns/1ps
module tlm_lin_to_fix
  import tlm_pkg::*;
(
  input  wire logic [15:0]          lin_i,
  output      logic signed [47:0]   fix_o
);

  // ************************************************************
  // Value is mantissa times two to the exponent
  // ************************************************************
  logic signed [4:0]  exp_s;
  logic        [5:0]  neg_sh;
  logic signed [47:0] mant_s;

  // Mantissa is pre-scaled so negative exponents keep their fraction
  always_comb begin
    exp_s  = lin_i[EXP_MSB:EXP_LSB];
    neg_sh = 6'(-{exp_s[4], exp_s});
    mant_s = {{37{lin_i[MANT_MSB]}}, lin_i[MANT_MSB:0]} <<< FRAC_W;
    if (!exp_s[4]) begin
      fix_o = mant_s <<< exp_s[3:0];
    end else begin
      fix_o = mant_s >>> neg_sh;
    end
  end

endmodule

// ### verilog/tlm_temp_limit_monitor.sv
// Temperature threshold registers, comparison and warning flags
//
// Function
// RULE_01: Over warning exceeded sets summary, flag, alert.
// RULE_02: Under warning crossed sets summary, flag, alert.
// RULE_03: Reaching under fault threshold reports fault.
// RULE_04: Over retry waits until below warning.
// RULE_05: Under retry waits until above warning.
// RULE_06: Host keeps over warning below fault. The monitor holds no over fault limit and does not check this.
// RULE_07: Host keeps under warning above fault. Not checked: any in-range under write is accepted.
// RULE_08: Out-of-range threshold writes rejected, value kept.
// RULE_09: Over warning accepts zero to 175 C.
// RULE_10: Under thresholds accept -55 to +25 C.
// RULE_11: Thresholds are linear: mantissa times two^exponent.
// RULE_12: Under triggers falling below; over rising above.
`timescale 1ns/1ps
module tlm_temp_limit_monitor
  import tlm_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wr_en_i,
  input  wire logic        rd_en_i,
  input  wire logic [7:0]  cmd_code_i,
  input  wire logic [15:0] wr_data_i,
  input  wire logic [15:0] temp_i,
  input  wire logic        clear_faults_i,
  input  wire logic        ot_retry_en_i,
  input  wire logic        ut_retry_en_i,
  output      logic [15:0] rd_data_o,
  output      logic        rd_ack_o,
  output      logic        cmd_reject_o,
  output      logic        status_temperature_o,
  output      logic        over_temp_warning_flag_o,
  output      logic        under_temp_warning_flag_o,
  output      logic        under_temp_fault_flag_o,
  output      logic        alert_o,
  output      logic        ot_restart_ok_o,
  output      logic        ut_restart_ok_o
);
  import tlm_pkg::*;

  // ************************************************************
  // Conversion of limits and measured temperature
  // ************************************************************
  logic [15:0]        ot_warn_ff, ut_warn_ff, ut_fault_ff;
  logic [15:0]        nxt_ot_warn, nxt_ut_warn, nxt_ut_fault;
  logic [15:0]        lin_vec [4];
  logic signed [47:0] fix_vec [4];
  logic signed [47:0] wr_fix;

  assign lin_vec[0] = ot_warn_ff;
  assign lin_vec[1] = ut_warn_ff;
  assign lin_vec[2] = ut_fault_ff;
  assign lin_vec[3] = temp_i;

  // One converter per compared quantity, all in the same format
  for (genvar g = 0; g < 4; g++) begin : g_conv
    tlm_lin_to_fix u_conv (                                   // RULE_11
      .lin_i (lin_vec[g]),
      .fix_o (fix_vec[g])
    );
  end

  tlm_lin_to_fix u_wr_conv (
    .lin_i (wr_data_i),
    .fix_o (wr_fix)
  );

  // Range check shared by all three limits
  function automatic logic in_range(input logic signed [47:0] v,
                                    input logic signed [47:0] lo,
                                    input logic signed [47:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  // ************************************************************
  // Register writes and reads
  // ************************************************************
  logic        ot_ok, ut_ok;
  logic [15:0] nxt_rd_data;
  logic        nxt_rd_ack, nxt_reject;
  logic        is_ot, is_ut, is_utf;

  // Rejected writes leave the limit untouched and raise a reject pulse
  always_comb begin
    is_ot        = cmd_code_i == CMD_OT_WARN;
    is_ut        = cmd_code_i == CMD_UT_WARN;
    is_utf       = cmd_code_i == CMD_UT_FAULT;
    ot_ok        = in_range(wr_fix, OT_MIN, OT_MAX);          // RULE_09
    ut_ok        = in_range(wr_fix, UT_MIN, UT_MAX);          // RULE_10
    nxt_ot_warn  = ot_warn_ff;
    nxt_ut_warn  = ut_warn_ff;
    nxt_ut_fault = ut_fault_ff;
    nxt_reject   = 1'b0;
    nxt_rd_ack   = 1'b0;
    nxt_rd_data  = rd_data_o;
    if (wr_en_i) begin
      if (is_ot && ot_ok) begin
        nxt_ot_warn = wr_data_i;
      end else if (is_ut && ut_ok) begin
        nxt_ut_warn = wr_data_i;
      end else if (is_utf && ut_ok) begin
        nxt_ut_fault = wr_data_i;
      end else begin
        nxt_reject = 1'b1;                                    // RULE_08
      end
    end else if (rd_en_i) begin
      nxt_rd_ack = 1'b1;
      if (is_ot) begin
        nxt_rd_data = ot_warn_ff;
      end else if (is_ut) begin
        nxt_rd_data = ut_warn_ff;
      end else if (is_utf) begin
        nxt_rd_data = ut_fault_ff;
      end else begin
        nxt_rd_data = 16'h0000;
        nxt_reject  = 1'b1;
      end
    end
  end

  // Register stage for the limits and read port
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ot_warn_ff   <= RST_OT_WARN;
      ut_warn_ff   <= RST_UT_WARN;
      ut_fault_ff  <= RST_UT_FAULT;
      rd_data_o    <= 16'h0000;
      rd_ack_o     <= 1'b0;
      cmd_reject_o <= 1'b0;
    end else begin
      ot_warn_ff   <= nxt_ot_warn;
      ut_warn_ff   <= nxt_ut_warn;
      ut_fault_ff  <= nxt_ut_fault;
      rd_data_o    <= nxt_rd_data;
      rd_ack_o     <= nxt_rd_ack;
      cmd_reject_o <= nxt_reject;
    end
  end

  // ************************************************************
  // Comparison, sticky flags and restart gating
  // ************************************************************
  logic ot_hit, ut_hit, utf_hit;
  logic nxt_otw, nxt_utw, nxt_utf, nxt_sum, nxt_alert;
  logic nxt_ot_rs, nxt_ut_rs;

  // A new crossing in the clearing cycle is kept: set wins over clear
  always_comb begin
    ot_hit    = fix_vec[3] >  fix_vec[0];                     // RULE_12
    ut_hit    = fix_vec[3] <  fix_vec[1];                     // RULE_12
    utf_hit   = fix_vec[3] <= fix_vec[2];                     // RULE_03
    nxt_otw   = (over_temp_warning_flag_o  & ~clear_faults_i) | ot_hit;
    nxt_utw   = (under_temp_warning_flag_o & ~clear_faults_i) | ut_hit;
    nxt_utf   = (under_temp_fault_flag_o   & ~clear_faults_i) | utf_hit;
    nxt_sum   = nxt_otw | nxt_utw | nxt_utf;                  // RULE_01
    nxt_alert = nxt_sum;                                      // RULE_02
    // Retry only once temperature is back on the safe side of warning
    nxt_ot_rs = ot_retry_en_i & (fix_vec[3] < fix_vec[0]);    // RULE_04
    nxt_ut_rs = ut_retry_en_i & (fix_vec[3] > fix_vec[1]);    // RULE_05
  end

  // Register stage for the status outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      over_temp_warning_flag_o  <= 1'b0;
      under_temp_warning_flag_o <= 1'b0;
      under_temp_fault_flag_o   <= 1'b0;
      status_temperature_o      <= 1'b0;
      alert_o                   <= 1'b0;
      ot_restart_ok_o           <= 1'b0;
      ut_restart_ok_o           <= 1'b0;
    end else begin
      over_temp_warning_flag_o  <= nxt_otw;
      under_temp_warning_flag_o <= nxt_utw;
      under_temp_fault_flag_o   <= nxt_utf;
      status_temperature_o      <= nxt_sum;
      alert_o                   <= nxt_alert;
      ot_restart_ok_o           <= nxt_ot_rs;
      ut_restart_ok_o           <= nxt_ut_rs;
    end
  end

  // ************************************************************
  // Assertions and covers
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ot_warn_set: assert property (                            // RULE_01
    fix_vec[3] > fix_vec[0] |=> over_temp_warning_flag_o && alert_o
      && status_temperature_o)
    else $error("over warning not raised");

  a_ut_warn_set: assert property (                            // RULE_02
    fix_vec[3] < fix_vec[1] |=> under_temp_warning_flag_o && alert_o
      && status_temperature_o)
    else $error("under warning not raised");

  a_ut_fault_set: assert property (                           // RULE_03
    fix_vec[3] <= fix_vec[2] |=> under_temp_fault_flag_o)
    else $error("under fault not raised");

  a_ot_retry_gate: assert property (                          // RULE_04
    ot_restart_ok_o |-> $past(fix_vec[3]) < $past(fix_vec[0])
      && $past(ot_retry_en_i))
    else $error("over restart while still hot");

  a_ut_retry_gate: assert property (                          // RULE_05
    ut_restart_ok_o |-> $past(fix_vec[3]) > $past(fix_vec[1])
      && $past(ut_retry_en_i))
    else $error("under restart while still cold");

  a_bad_write_kept: assert property (                         // RULE_08
    wr_en_i && is_ot && !ot_ok |=> $stable(ot_warn_ff) && cmd_reject_o)
    else $error("bad write changed limit");

  a_ot_in_range: assert property (                            // RULE_09
    fix_vec[0] >= OT_MIN && fix_vec[0] <= OT_MAX)
    else $error("over warning limit out of range");

  a_ut_in_range: assert property (                            // RULE_10
    fix_vec[1] >= UT_MIN && fix_vec[1] <= UT_MAX
      && fix_vec[2] >= UT_MIN && fix_vec[2] <= UT_MAX)
    else $error("under limit out of range");

  a_flag_sticky: assert property (                            // RULE_12
    over_temp_warning_flag_o && !clear_faults_i
      |=> over_temp_warning_flag_o)
    else $error("flag dropped without clear");

  c_ot_trip:   cover property (!over_temp_warning_flag_o
                               ##1 over_temp_warning_flag_o);
  c_rejected:  cover property (wr_en_i ##1 cmd_reject_o);
  c_restart:   cover property (over_temp_warning_flag_o ##[1:20]
                               ot_restart_ok_o);

endmodule

// ### verification/tlm_host_model.sv
// Host controller model issuing threshold writes and reads
`timescale 1ns/1ps
module tlm_host_model (
  input  wire logic        clk_i,
  output      logic        wr_en_o,
  output      logic        rd_en_o,
  output      logic [7:0]  cmd_o,
  output      logic [15:0] data_o
);
  initial begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    cmd_o   = 8'h00;
    data_o  = 16'h0000;
  end
  // One request held over one rising edge, then the bus is released
  task automatic xfer(input logic w, input logic [7:0] c,
                      input logic [15:0] d);
    @(negedge clk_i);
    wr_en_o = w;
    rd_en_o = !w;
    cmd_o   = c;
    data_o  = d;
    @(negedge clk_i);
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    data_o  = ~d;  // Released data shows no stale value
  endtask
endmodule

// ### verification/tlm_temp_limit_monitor_bench.sv
// Self-checking bench for the temperature limit monitor
`timescale 1ns/1ps
module tlm_temp_limit_monitor_bench;
  import tlm_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        clr = 1'b0, ot_re = 1'b0, ut_re = 1'b0;
  logic [15:0] temp_i = 16'h0014;
  logic        wr_en, rd_en, ack, rej, st, otw, utw, utf, alrt, ook, uok;
  logic [7:0]  cmd;
  logic [15:0] wdat, rdat, d;
  logic [17:0] exp_q[$];
  logic [40:0] tbl[13];
  int          err_count = 0, n_tests = 0, seed = 32'hc84d;

  always #2 clk_i = ~clk_i;

  tlm_host_model u_tlm_host_model (.clk_i(clk_i), .wr_en_o(wr_en),
    .rd_en_o(rd_en), .cmd_o(cmd), .data_o(wdat));
  tlm_temp_limit_monitor u_tlm_temp_limit_monitor (.clk_i(clk_i),
    .rst_i(rst_i), .wr_en_i(wr_en), .rd_en_i(rd_en), .cmd_code_i(cmd),
    .wr_data_i(wdat), .temp_i(temp_i), .clear_faults_i(clr),
    .ot_retry_en_i(ot_re), .ut_retry_en_i(ut_re), .rd_data_o(rdat),
    .rd_ack_o(ack), .cmd_reject_o(rej), .status_temperature_o(st),
    .over_temp_warning_flag_o(otw), .under_temp_warning_flag_o(utw),
    .under_temp_fault_flag_o(utf), .alert_o(alrt),
    .ot_restart_ok_o(ook), .ut_restart_ok_o(uok));

  task automatic chk(input string nm, input logic [17:0] ex, got);
    n_tests++;
    if (got !== ex) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, ex, got);
    end
  endtask
  // Expected answer noted before the request goes out
  task automatic wr(input logic [7:0] c, input logic [15:0] v, input bad);
    if (bad) exp_q.push_back({2'b01, 16'h0});
    u_tlm_host_model.xfer(1'b1, c, v);
  endtask
  task automatic rd(input logic [7:0] c, input rj, input logic [15:0] v);
    exp_q.push_back({1'b1, rj, v});
    u_tlm_host_model.xfer(1'b0, c, 16'h0);
  endtask
  // Flags seen as {summary,over,under,fault,alert,ot_ok,ut_ok}
  task automatic tmp(input logic [15:0] t, input logic [6:0] ex);
    @(negedge clk_i);
    temp_i = t;
    repeat (2) @(negedge clk_i);
    chk("flags", {11'h0, ex}, {11'h0, st, otw, utw, utf, alrt, ook, uok});
  endtask
  task automatic clear;
    @(negedge clk_i);
    clr = 1'b1;
    @(negedge clk_i);
    clr = 1'b0;
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Answer watcher: every ack or reject takes the oldest note
  always @(negedge clk_i) begin
    if (ack || rej) begin
      chk("answer", exp_q.size() ? exp_q.pop_front() : 18'h0,
          {ack, rej, ack ? rdat : 16'h0});
    end
  end

  initial begin
    #40000;
    err_count++;
    close_out();
  end

  // Table of {code, refused, written, read back}
  initial begin
    tbl = '{{CMD_OT_WARN, 1'b0, 16'h00af, 16'h00af},
      {CMD_OT_WARN, 1'b1, 16'h00b0, 16'h00af},
      {CMD_OT_WARN, 1'b1, 16'hffff, 16'h00af},
      {CMD_OT_WARN, 1'b0, 16'h0000, 16'h0000},
      {CMD_OT_WARN, 1'b0, 16'h0832, 16'h0832},
      {CMD_UT_WARN, 1'b0, 16'h07c9, 16'h07c9},
      {CMD_UT_WARN, 1'b1, 16'h07c8, 16'h07c9},
      {CMD_UT_WARN, 1'b1, 16'h001a, 16'h07c9},
      {CMD_UT_WARN, 1'b0, 16'h0019, 16'h0019},
      {CMD_UT_FAULT, 1'b0, 16'h07c9, 16'h07c9},
      {CMD_UT_FAULT, 1'b1, 16'h001a, 16'h07c9},
      {CMD_UT_FAULT, 1'b0, 16'h07d3, 16'h07d3},
      {CMD_UT_WARN, 1'b0, 16'h07d8, 16'h07d8}};
    repeat (20) @(negedge clk_i);
    rst_i = 1'b0;
    chk("reset flags", 18'h0, {11'h0, st, otw, utw, utf, alrt, ook, uok});
    rd(CMD_OT_WARN, 1'b0, RST_OT_WARN);
    rd(CMD_UT_WARN, 1'b0, RST_UT_WARN);
    rd(CMD_UT_FAULT, 1'b0, RST_UT_FAULT);
    rd(8'h54, 1'b1, 16'h0);
    wr(8'h50, 16'h0019, 1'b1);
    $display("test reset values done");
    // Range edges, an exponent encoding and refused writes
    foreach (tbl[i]) begin
      wr(tbl[i][40:33], tbl[i][31:16], tbl[i][32]);
      rd(tbl[i][40:33], 1'b0, tbl[i][15:0]);
    end
    $display("test ranges done");
    // Range writes left sticky flags behind; start from a clean status
    clear();
    tmp(16'h0064, 7'h00);
    tmp(16'h0065, 7'b1100100);
    tmp(16'h0014, 7'b1100100);
    clear();
    tmp(16'h0014, 7'h00);
    tmp(16'h07d8, 7'h00);
    tmp(16'h07d7, 7'b1010100);
    tmp(16'h07d4, 7'b1010100);
    tmp(16'h07d3, 7'b1011100);
    // Clear while still at the fault limit: the new hit wins
    clear();
    tmp(16'h0014, 7'b1011100);
    clear();
    tmp(16'h0014, 7'h00);
    $display("test flags done");
    ot_re = 1'b1;
    ut_re = 1'b1;
    tmp(16'h0014, 7'b0000011);
    tmp(16'h0064, 7'b0000001);
    tmp(16'h07d8, 7'b0000010);
    $display("test restart done");
    // Random accepted over warning values read back
    repeat (4) begin
      d = 16'({$random(seed)} % 176);
      wr(CMD_OT_WARN, d, 1'b0);
      rd(CMD_OT_WARN, 1'b0, d);
    end
    repeat (3) @(negedge clk_i);
    chk("pending", 18'h0, 18'(exp_q.size()));
    $display("test random done");
    close_out();
  end
endmodule
